// ===== include/swc_edge_if.sv
`timescale 1ns/10ps
`default_nettype none
//----------------------------------------------------------------------
// Filtered pin level and its rising edge
//----------------------------------------------------------------------
interface swc_edge_if;
   logic level;
   logic rise;
   modport src (output level, output rise);
   modport dst (input level, input rise);
endinterface
`default_nettype wire

// ===== include/swc_pkg.sv
`default_nettype none
//----------------------------------------------------------------------
// Shared constants for the sleep and wake controller
//----------------------------------------------------------------------
package swc_pkg;
   // Sleep timer and watchdog
   localparam int SLEEP_TIMER_W = 15;
   localparam logic [7:0] WDT_CLEAR_BOTH = 8'h38;
   localparam logic [1:0] WDT_ROLLOVER_LIMIT = 2'h3;
   // Interval select picks the top count bit of one period
   localparam int SLEEP_TAP_BIT [4] = '{5, 8, 11, 14};
   // Clock rate
   localparam int CLK_PERIOD_NS = 20;
   localparam int CYC_PER_US = 1000 / CLK_PERIOD_NS;
   // Wakeup sequence timing
   localparam logic [1:0] PWR_GOOD_SLOW_CYC = 2'h3;
   localparam int T0_TAP_US [4] = '{10, 14, 20, 30};
   localparam int T1_TAP_US [4] = '{3, 4, 5, 10};
   localparam int T2_TAP_US [4] = '{1, 2, 5, 10};
   localparam int T23_US = 1;
   localparam int SEQ_W = 12;
   // Wakeup tap configuration fields
   localparam int TAP_CFG_W = 7;
   localparam int TAP_T0_LSB = 0;
   localparam int TAP_T1_LSB = 2;
   localparam int TAP_T2_LSB = 4;
   localparam int TAP_DBL_BIT = 6;

   typedef enum logic [3:0] {
      ST_AWAKE    = 4'h0,
      ST_HALT_REQ = 4'h1,
      ST_PD_EDGE  = 4'h2,
      ST_SLEEP    = 4'h3,
      ST_PWR_GOOD = 4'h4,
      ST_T0       = 4'h5,
      ST_T1       = 4'h6,
      ST_T2       = 4'h7,
      ST_T3       = 4'h8
   } swc_state_t;
endpackage
`default_nettype wire

// ===== logic/swc_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module swc_pin_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Raw pin
   input wire logic pin,
   // Filtered level and edge
   swc_edge_if.src sync
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic level_q;
   logic rise_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Change only counts once two stages agree
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         level_q <= 1'b0;
         rise_q <= 1'b0;
      end else begin
         rise_q <= (s2_q == s3_q) & s3_q & ~level_q;
         if (s2_q == s3_q) begin
            level_q <= s3_q;
         end
      end
   end

   assign sync.level = level_q;
   assign sync.rise = rise_q;
endmodule // swc_pin_sync
`default_nettype wire

// ===== logic/swc_sleep_wake_controller.sv
`timescale 1ns/10ps
`default_nettype none
//----------------------------------------------------------------------
//----------------------------------------------------------------------
module swc_sleep_wake_controller #(
   parameter int TIMER_W = swc_pkg::SLEEP_TIMER_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Clock pins
   input wire logic clk32_pin,
   input wire logic slow_osc_pin,
   // CPU side
   input wire logic sleep_bit_wr,
   input wire logic irq_pending_enabled,
   input wire logic cpu_halt_acknowledge,
   input wire logic cpu_stop_bit,
   input wire logic debug_mode,
   input wire logic watchdog_clear_wr,
   input wire logic [7:0] watchdog_clear_data,
   // Configuration bits
   input wire logic sleep_int_en,
   input wire logic [1:0] sleep_interval_sel,
   input wire logic crystal_enable_bit,
   input wire logic crystal_exists_flag,
   input wire logic i2c_standby_en,
   input wire logic slow_osc_off_bit,
   input wire logic [swc_pkg::TAP_CFG_W-1:0] wakeup_tap_config,
   // Masked-in interrupt sources and supply monitor
   input wire logic gpio_int,
   input wire logic timer0_int,
   input wire logic i2c_int,
   input wire logic buzz_active,
   input wire logic low_voltage_detect,
   // Status and control
   output logic cpu_halt_request,
   output logic power_down_signal,
   output logic sleep_bit,
   output logic [TIMER_W-1:0] sleep_timer_count,
   output logic sleep_timer_irq,
   output logic low_voltage_irq,
   output logic watchdog_reset_event,
   output logic slow_osc_power_down,
   output logic clk32_running,
   output logic i2c_sleep_active,
   output logic isr_defer
);
   import swc_pkg::*;

   if (TIMER_W < SLEEP_TAP_BIT[3] + 1) begin : g_bad_width
      $error("TIMER_W too narrow for the interval taps");
   end

   //-------------------------------------------------------------------
   // Pin synchronisers
   //-------------------------------------------------------------------
   swc_edge_if clk32_e ();
   swc_edge_if slow_e ();

   swc_pin_sync u_clk32_sync (
      .clk(clk),
      .rst_b(rst_b),
      .pin(clk32_pin),
      .sync(clk32_e.src)
   );

   swc_pin_sync u_slow_sync (
      .clk(clk),
      .rst_b(rst_b),
      .pin(slow_osc_pin),
      .sync(slow_e.src)
   );

   //-------------------------------------------------------------------
   // State and decode
   //-------------------------------------------------------------------
   swc_state_t state_q;
   logic sleep_bit_q;
   logic [TIMER_W-1:0] timer_q;
   logic [1:0] wdt_q;
   logic wdt_pend_q;
   logic deep_q;
   logic i2c_mode_q;
   logic [SEQ_W-1:0] seq_q;
   logic [1:0] pg_q;
   logic cpu_halt_request_q;
   logic power_down_q;
   logic sleep_timer_irq_q;
   logic low_voltage_irq_q;
   logic watchdog_reset_q;
   logic slow_osc_pd_q;
   logic clk32_running_q;
   logic i2c_sleep_q;
   logic isr_defer_q;

   logic clk32_blocked;
   logic tick;
   logic timer_run;
   logic rollover;
   logic [TIMER_W-1:0] int_mask;
   logic st_irq_ev;
   logic st_clr;
   logic wdt_fire;
   logic wdt_issue;
   logic sleeping;
   logic deep_req;
   logic lvd_ev;
   logic wake;
   logic dbl;

   function automatic logic [SEQ_W-1:0] tap_cyc(input int us, input logic twice);
      int c;
      c = us * CYC_PER_US;
      if (twice) begin
         c = c * 2;
      end
      return SEQ_W'(c - 1);
   endfunction

   // No 32 kHz clock at all when the crystal is enabled but absent
   assign clk32_blocked = crystal_enable_bit & ~crystal_exists_flag;
   assign tick = clk32_e.rise & ~clk32_blocked;
   // Breakpoints must not trip the watchdog over and over
   assign timer_run = ~(deep_q & (state_q == ST_SLEEP)) & ~(debug_mode & cpu_stop_bit);
   assign rollover = tick & timer_run & (&timer_q);
   assign st_irq_ev = tick & timer_run & ((timer_q & int_mask) == int_mask);
   assign st_clr = watchdog_clear_wr & (watchdog_clear_data == WDT_CLEAR_BOTH);
   assign wdt_fire = rollover & ~watchdog_clear_wr & (wdt_q == WDT_ROLLOVER_LIMIT - 2'h1);
   assign sleeping = (state_q != ST_AWAKE);
   // A watchdog event while asleep waits for the wakeup to finish
   assign wdt_issue = (wdt_fire & ~sleeping) | (wdt_pend_q & ~sleeping);
   // A crystal enable keeps the device out of deep sleep
   assign deep_req = slow_osc_off_bit & ~i2c_standby_en & ~crystal_enable_bit;
   assign lvd_ev = (state_q == ST_SLEEP) & ~deep_q & buzz_active & low_voltage_detect;
   assign dbl = wakeup_tap_config[TAP_DBL_BIT];

   always_comb begin
      int_mask = '0;
      for (int i = 0; i < TIMER_W; i++) begin
         int_mask[i] = (i <= SLEEP_TAP_BIT[sleep_interval_sel]);
      end
   end

   // Sources are the masked-in levels; global enable plays no part
   always_comb begin
      if (deep_q) begin
         wake = gpio_int;
      end else begin
         wake = (sleep_int_en & st_irq_ev) | gpio_int | timer0_int | lvd_ev | wdt_pend_q | wdt_fire;
         if (i2c_mode_q) begin
            wake = wake | i2c_int;
         end
      end
   end

   //-------------------------------------------------------------------
   // Sleep timer and watchdog
   //-------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         timer_q <= '0;
      end else if (wdt_issue || st_clr) begin
         timer_q <= '0;
      end else if (tick && timer_run) begin
         timer_q <= timer_q + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wdt_q <= 2'h0;
      end else if (watchdog_clear_wr || wdt_issue) begin
         wdt_q <= 2'h0;
      end else if (rollover) begin
         wdt_q <= wdt_fire ? 2'h0 : wdt_q + 2'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wdt_pend_q <= 1'b0;
      end else if (wdt_fire && sleeping) begin
         wdt_pend_q <= 1'b1;
      end else if (wdt_issue) begin
         wdt_pend_q <= 1'b0;
      end
   end

   //-------------------------------------------------------------------
   // Sleep bit
   //-------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sleep_bit_q <= 1'b0;
      end else if (wdt_issue) begin
         sleep_bit_q <= 1'b0;
      end else if (state_q == ST_AWAKE && sleep_bit_wr && !irq_pending_enabled) begin
         sleep_bit_q <= 1'b1;
      end else if (state_q == ST_SLEEP && wake) begin
         sleep_bit_q <= 1'b0;
      end
   end

   //-------------------------------------------------------------------
   // Entry and wakeup sequencer
   //-------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ST_AWAKE;
         cpu_halt_request_q <= 1'b0;
         power_down_q <= 1'b0;
         deep_q <= 1'b0;
         i2c_mode_q <= 1'b0;
         seq_q <= '0;
         pg_q <= 2'h0;
         isr_defer_q <= 1'b0;
      end else begin
         isr_defer_q <= 1'b0;
         unique case (state_q)
            ST_AWAKE: begin
               if (sleep_bit_q && !wdt_issue) begin
                  state_q <= ST_HALT_REQ;
                  cpu_halt_request_q <= 1'b1;
               end
            end
            ST_HALT_REQ: begin
               if (cpu_halt_acknowledge) begin
                  state_q <= ST_PD_EDGE;
               end
            end
            ST_PD_EDGE: begin
               // Stands in for the falling edge; wake sources unseen here
               state_q <= ST_SLEEP;
               power_down_q <= 1'b1;
               deep_q <= deep_req;
               i2c_mode_q <= i2c_standby_en & ~deep_req;
            end
            ST_SLEEP: begin
               if (!sleep_bit_q) begin
                  state_q <= ST_PWR_GOOD;
                  pg_q <= 2'h0;
                  deep_q <= 1'b0;
               end
            end
            ST_PWR_GOOD: begin
               if (slow_e.rise) begin
                  if (pg_q == PWR_GOOD_SLOW_CYC - 2'h1) begin
                     // Main oscillator back so the taps can be timed
                     state_q <= ST_T0;
                     power_down_q <= 1'b0;
                     seq_q <= tap_cyc(T0_TAP_US[wakeup_tap_config[TAP_T0_LSB +: 2]], dbl);
                  end else begin
                     pg_q <= pg_q + 2'h1;
                  end
               end
            end
            ST_T0: begin
               if (seq_q == '0) begin
                  state_q <= ST_T1;
                  seq_q <= tap_cyc(T1_TAP_US[wakeup_tap_config[TAP_T1_LSB +: 2]], dbl);
               end else begin
                  seq_q <= seq_q - 1'b1;
               end
            end
            ST_T1: begin
               if (seq_q == '0) begin
                  state_q <= ST_T2;
                  seq_q <= tap_cyc(T23_US, 1'b0);
               end else begin
                  seq_q <= seq_q - 1'b1;
               end
            end
            ST_T2: begin
               if (seq_q == '0) begin
                  state_q <= ST_T3;
                  seq_q <= tap_cyc(T2_TAP_US[wakeup_tap_config[TAP_T2_LSB +: 2]], dbl);
               end else begin
                  seq_q <= seq_q - 1'b1;
               end
            end
            ST_T3: begin
               if (seq_q == '0) begin
                  // Prefetched instruction goes ahead of any handler
                  state_q <= ST_AWAKE;
                  cpu_halt_request_q <= 1'b0;
                  i2c_mode_q <= 1'b0;
                  isr_defer_q <= 1'b1;
               end else begin
                  seq_q <= seq_q - 1'b1;
               end
            end
            default: begin
               state_q <= ST_AWAKE;
               cpu_halt_request_q <= 1'b0;
               power_down_q <= 1'b0;
            end
         endcase
      end
   end

   //-------------------------------------------------------------------
   // Event and status outputs
   //-------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sleep_timer_irq_q <= 1'b0;
         low_voltage_irq_q <= 1'b0;
         watchdog_reset_q <= 1'b0;
      end else begin
         sleep_timer_irq_q <= st_irq_ev & sleep_int_en;
         low_voltage_irq_q <= lvd_ev;
         watchdog_reset_q <= wdt_issue;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         slow_osc_pd_q <= 1'b0;
         clk32_running_q <= 1'b0;
         i2c_sleep_q <= 1'b0;
      end else begin
         slow_osc_pd_q <= (state_q == ST_SLEEP) & deep_q;
         clk32_running_q <= ~clk32_blocked;
         i2c_sleep_q <= (state_q == ST_SLEEP) & i2c_mode_q;
      end
   end

   assign cpu_halt_request = cpu_halt_request_q;
   assign power_down_signal = power_down_q;
   assign sleep_bit = sleep_bit_q;
   assign sleep_timer_count = timer_q;
   assign sleep_timer_irq = sleep_timer_irq_q;
   assign low_voltage_irq = low_voltage_irq_q;
   assign watchdog_reset_event = watchdog_reset_q;
   assign slow_osc_power_down = slow_osc_pd_q;
   assign clk32_running = clk32_running_q;
   assign i2c_sleep_active = i2c_sleep_q;
   assign isr_defer = isr_defer_q;

   //-------------------------------------------------------------------
   // Checks
   //-------------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   sequence s_ack_taken;
      state_q == ST_HALT_REQ && cpu_halt_acknowledge;
   endsequence
   sequence s_pd_next_edge;
      !power_down_q ##1 power_down_q && cpu_halt_request_q;
   endsequence

   property p_timer_step;
      tick && timer_run && !st_clr && !wdt_issue |=> timer_q == $past(timer_q) + 1'b1;
   endproperty
   a_timer_step: assert property (p_timer_step) else $error("sleep timer missed a step");

   property p_timer_hold;
      !timer_run && !st_clr && !wdt_issue |=> $stable(timer_q);
   endproperty
   a_timer_hold: assert property (p_timer_hold) else $error("sleep timer moved while stopped");

   property p_period_irq;
      st_irq_ev && sleep_int_en |=> sleep_timer_irq_q;
   endproperty
   a_period_irq: assert property (p_period_irq) else $error("periodic interrupt missing");

   property p_clear38;
      st_clr |=> timer_q == '0 && wdt_q == 2'h0;
   endproperty
   a_clear38: assert property (p_clear38) else $error("38h write did not clear both");

   property p_block_sleep;
      state_q == ST_AWAKE && !sleep_bit_q && sleep_bit_wr && irq_pending_enabled |=> !sleep_bit_q;
   endproperty
   a_block_sleep: assert property (p_block_sleep) else $error("sleep bit set under pending irq");

   property p_pd_order;
      s_ack_taken |=> s_pd_next_edge;
   endproperty
   a_pd_order: assert property (p_pd_order) else $error("power down not one edge after ack");

   property p_deep_gpio_only;
      state_q == ST_SLEEP && deep_q && !gpio_int |=> sleep_bit_q;
   endproperty
   a_deep_gpio_only: assert property (p_deep_gpio_only) else $error("deep sleep left without gpio");

   property p_pg_three;
      $rose(state_q == ST_T0) |-> $past(state_q) == ST_PWR_GOOD && $past(pg_q) == 2'h2;
   endproperty
   a_pg_three: assert property (p_pg_three) else $error("power good not three slow cycles");

   property p_wdt_third;
      rollover && wdt_q == 2'h2 && !watchdog_clear_wr |=> watchdog_reset_q || wdt_pend_q;
   endproperty
   a_wdt_third: assert property (p_wdt_third) else $error("watchdog missed third rollover");

   property p_wdt_after_wake;
      watchdog_reset_q |-> state_q == ST_AWAKE && !$past(power_down_q);
   endproperty
   a_wdt_after_wake: assert property (p_wdt_after_wake) else $error("watchdog reset during sleep");

   property p_entry_ignore;
      state_q == ST_PD_EDGE |=> state_q == ST_SLEEP && sleep_bit_q;
   endproperty
   a_entry_ignore: assert property (p_entry_ignore) else $error("interrupt acted before power down");
endmodule // swc_sleep_wake_controller
`default_nettype wire

// ===== testbench/swc_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module swc_cpu_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Halt handshake
   input wire logic halt_req,
   output logic halt_ack
);
   // Acknowledge lands on the edge right after the request
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         halt_ack <= 1'b0;
      end else begin
         halt_ack <= halt_req;
      end
   end
endmodule // swc_cpu_model
`default_nettype wire

// ===== testbench/swc_sleep_wake_controller_tb.sv
`timescale 1ns/10ps
`default_nettype none
module swc_sleep_wake_controller_tb;
   import swc_pkg::*;
   logic clk, rst_b, clk32_pin, slow_osc_pin, sleep_bit_wr, irq_pending_enabled, ack, cpu_stop_bit, debug_mode;
   logic watchdog_clear_wr, sleep_int_en, crystal_enable_bit, crystal_exists_flag, i2c_standby_en;
   logic slow_osc_off_bit, buzz, halt_req, pd, sleep_bit, st_irq, lv_irq, osc_pd, running, i2c_act, isr_defer;
   logic [7:0] wd_data;
   logic [1:0] sel;
   logic wd_rst;
   logic [6:0] tap_cfg;
   logic [3:0] src;
   logic [14:0] count;
   int miscompares, check_count, irq_seen, lv_seen, wd_seen;
   swc_sleep_wake_controller dut (.clk(clk), .rst_b(rst_b), .clk32_pin(clk32_pin), .slow_osc_pin(slow_osc_pin),
      .sleep_bit_wr(sleep_bit_wr), .irq_pending_enabled(irq_pending_enabled), .cpu_halt_acknowledge(ack),
      .cpu_stop_bit(cpu_stop_bit), .debug_mode(debug_mode), .watchdog_clear_wr(watchdog_clear_wr),
      .watchdog_clear_data(wd_data), .sleep_int_en(sleep_int_en), .sleep_interval_sel(sel),
      .crystal_enable_bit(crystal_enable_bit), .crystal_exists_flag(crystal_exists_flag),
      .i2c_standby_en(i2c_standby_en), .slow_osc_off_bit(slow_osc_off_bit), .wakeup_tap_config(tap_cfg),
      .gpio_int(src[0]), .timer0_int(src[1]), .i2c_int(src[2]), .buzz_active(buzz),
      .low_voltage_detect(src[3]), .cpu_halt_request(halt_req), .power_down_signal(pd), .sleep_bit(sleep_bit),
      .sleep_timer_count(count), .sleep_timer_irq(st_irq), .low_voltage_irq(lv_irq),
      .watchdog_reset_event(wd_rst), .slow_osc_power_down(osc_pd), .clk32_running(running),
      .i2c_sleep_active(i2c_act), .isr_defer(isr_defer));
   swc_cpu_model cpu (.clk(clk), .rst_b(rst_b), .halt_req(halt_req), .halt_ack(ack));
   //----------------------------------------------------------------------
   // Clocks and event counters
   //----------------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      slow_osc_pin = 1'b0;
      forever begin
         repeat (5) @(negedge clk);
         slow_osc_pin = ~slow_osc_pin;
      end
   end
   always @(posedge clk) begin
      if (st_irq === 1'b1) irq_seen++;
      if (lv_irq === 1'b1) lv_seen++;
      if (wd_rst === 1'b1) wd_seen++;
   end
   //----------------------------------------------------------------------
   // Helpers
   //----------------------------------------------------------------------
   task automatic report_and_stop();
      if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic bound(input int n, input int lim);
      if (n >= lim) begin
         miscompares++;
         report_and_stop();
      end
   endtask
   // Eight clk per tick leaves room for the pin synchroniser
   task automatic tick32(input int n);
      repeat (n) begin
         clk32_pin = 1'b1;
         repeat (4) @(negedge clk);
         clk32_pin = 1'b0;
         repeat (4) @(negedge clk);
      end
      repeat (6) @(negedge clk);
   endtask
   task automatic wd_clear(input logic [7:0] d);
      watchdog_clear_wr = 1'b1;
      wd_data = d;
      @(negedge clk);
      watchdog_clear_wr = 1'b0;
      repeat (2) @(negedge clk);
   endtask
   // A pulse on a source before power down must leave the device asleep
   task automatic enter_sleep(input logic [3:0] stray);
      int n;
      sleep_bit_wr = 1'b1;
      @(negedge clk);
      sleep_bit_wr = 1'b0;
      check(sleep_bit, 1'b1);
      src = src | stray;
      repeat (2) @(negedge clk);
      src = src & ~stray;
      for (n = 0; n < 50 && pd !== 1'b1; n++) @(negedge clk);
      bound(n, 50);
      check(ack, 1'b1);
      repeat (3) @(negedge clk);
      if (stray != 4'h0) check(sleep_bit, 1'b1);
   endtask
   // us: main clock time expected after power good
   task automatic wake(input logic [3:0] s, input bit keep, input int us);
      int n;
      src = src | s;
      for (n = 0; n < 10 && sleep_bit !== 1'b0; n++) @(negedge clk);
      bound(n, 10);
      for (n = 0; n < 300 && pd !== 1'b0; n++) @(negedge clk);
      bound(n, 300);
      for (n = 0; n < 4000 && isr_defer !== 1'b1; n++) @(negedge clk);
      bound(n, 4000);
      check(n > us * CYC_PER_US - 4 && n < us * CYC_PER_US + 4, 1'b1);
      check(halt_req, 1'b0);
      @(negedge clk);
      check(isr_defer, 1'b0);
      if (!keep) src = 4'h0;
      repeat (2) @(negedge clk);
   endtask
   //----------------------------------------------------------------------
   // Scenarios
   //----------------------------------------------------------------------
   task automatic scen_timer();
      check(count, 15'h0000);
      check(running, 1'b1);
      tick32(5);
      check(count, 15'h0005);
      wd_clear(8'h12);
      check(count, 15'h0005);
      wd_clear(8'h38);
      check(count, 15'h0000);
      debug_mode = 1'b1;
      cpu_stop_bit = 1'b1;
      tick32(3);
      check(count, 15'h0000);
      cpu_stop_bit = 1'b0;
      tick32(3);
      check(count, 15'h0003);
      debug_mode = 1'b0;
   endtask
   task automatic scen_periodic();
      wd_clear(8'h38);
      sleep_int_en = 1'b1;
      tick32(64);
      check(irq_seen, 1);
      tick32(64);
      check(irq_seen, 2);
      check(count, 15'h0080);
      // Longer interval: next event only at the 512 boundary
      sel = 2'h1;
      tick32(383);
      check(irq_seen, 2);
      tick32(1);
      check(irq_seen, 3);
      check(count, 15'h0200);
      sleep_int_en = 1'b0;
   endtask
   task automatic scen_crystal();
      crystal_enable_bit = 1'b1;
      repeat (2) @(negedge clk);
      check(running, 1'b0);
      tick32(3);
      check(count, 15'h0200);
      crystal_enable_bit = 1'b0;
   endtask
   task automatic scen_blocked();
      irq_pending_enabled = 1'b1;
      sleep_bit_wr = 1'b1;
      @(negedge clk);
      sleep_bit_wr = 1'b0;
      repeat (3) @(negedge clk);
      check(sleep_bit | halt_req, 1'b0);
      irq_pending_enabled = 1'b0;
   endtask
   task automatic scen_standby();
      enter_sleep(4'h1);
      check(i2c_act, 1'b0);
      wake(4'h1, 1'b1, 15);
      // Source left pending: sleep is left at once
      enter_sleep(4'h0);
      check(sleep_bit, 1'b0);
      wake(4'h1, 1'b0, 15);
      // Taps 1,1,1 doubled: 2 * (14 + 4 + 2) + 1 us
      tap_cfg = 7'h55;
      enter_sleep(4'h0);
      wake(4'h2, 1'b0, 41);
      tap_cfg = 7'h00;
      i2c_standby_en = 1'b1;
      enter_sleep(4'h0);
      check(i2c_act, 1'b1);
      wake(4'h4, 1'b0, 15);
      i2c_standby_en = 1'b0;
      buzz = 1'b1;
      enter_sleep(4'h0);
      wake(4'h8, 1'b0, 15);
      check(lv_seen > 0, 1'b1);
      buzz = 1'b0;
   endtask
   task automatic scen_deep();
      // Firmware order: I2C standby and crystal already off, then slow osc off
      slow_osc_off_bit = 1'b1;
      enter_sleep(4'h0);
      check(osc_pd, 1'b1);
      src = 4'h2;
      repeat (20) @(negedge clk);
      check(sleep_bit, 1'b1);
      src = 4'h0;
      wake(4'h1, 1'b0, 15);
      check(osc_pd, 1'b0);
      slow_osc_off_bit = 1'b0;
   endtask
   //----------------------------------------------------------------------
   // Main sequence
   //----------------------------------------------------------------------
   initial begin
      {rst_b, clk32_pin, sleep_bit_wr, irq_pending_enabled, cpu_stop_bit, debug_mode, watchdog_clear_wr} = '0;
      {sleep_int_en, crystal_enable_bit, crystal_exists_flag, i2c_standby_en, slow_osc_off_bit, buzz} = '0;
      {wd_data, sel, src, tap_cfg, miscompares, check_count, irq_seen, lv_seen, wd_seen} = '0;
      repeat (8) @(negedge clk);
      rst_b = 1'b1;
      repeat (2) @(negedge clk);
      scen_timer();
      scen_periodic();
      scen_crystal();
      scen_blocked();
      scen_standby();
      scen_deep();
      // Timer never nears a rollover, so no watchdog event may appear
      check(wd_seen, 0);
      report_and_stop();
   end
endmodule // swc_sleep_wake_controller_tb
`default_nettype wire
